// ---- pspe_host.sv ----
// Purpose: external 8-bit processor on the slave port pins
// Assumes: strobes change just after a rising hclk edge
// Notes:   undriven data lines toggle so a stale byte never passes
`timescale 1ns/1ps
module pspe_host (
	input wire logic			hclk,
	input wire logic [7:0]		port_d_out,
	input wire logic [7:0]		port_d_oe,
	output pspe_pkg::pspe_strobe_t	strobe,
	output logic [7:0]			pins
);
	import pspe_pkg::*;
	logic [7:0]	dat = 8'h00;
	logic [7:0]	last = 8'h00;
	logic		drv = 1'b0;
	initial strobe = 3'h7;
	assign pins = port_d_oe[0] ? port_d_out : (drv ? dat : ~last);
	always @(posedge hclk) last <= pins;
	// no wait for a read of the latch: a second call overruns it on purpose
	task automatic xwr(input logic [7:0] v);
		strobe <= 3'h1;
		dat <= v;
		drv <= 1'b1;
		repeat (4) @(posedge hclk);
		strobe <= 3'h7;
		drv <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask
	task automatic xrd(output logic [7:0] v);
		strobe <= 3'h2;
		repeat (5) @(posedge hclk);
		v = pins;
		strobe <= 3'h7;
		repeat (4) @(posedge hclk);
	endtask
endmodule // pspe_host

// ---- pspe_pkg.sv ----
// Purpose: shared types of the slave port block
// Assumes: nothing
// Notes:   strobes are active low at the pins
package pspe_pkg;

	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} pspe_strobe_t;

	typedef struct packed {
		logic [2:0] dout;
		logic [2:0] oe;
	} pspe_pe_drive_t;

	typedef enum logic {PSPE_IDLE, PSPE_DATA} pspe_bus_state_t;

endpackage

// ---- pspe_properties.sv ----
// Purpose: port checks of the slave port register bank
// Assumes: one clock, hresetn async active low
// Notes:   strobes pass a two-flop synchroniser, so pin checks allow slack
`timescale 1ns/1ps
module pspe_properties (
	input wire logic			hclk,
	input wire logic			hresetn,
	input wire logic			warm_reset,
	input wire logic			hsel,
	input wire logic [1:0]		htrans,
	input wire logic			hready,
	input wire logic			hreadyout,
	input wire logic [31:0]		hrdata,
	input wire pspe_pkg::pspe_strobe_t	strobe_in,
	input wire logic [7:0]		port_d_oe,
	input wire logic [2:0]		port_e_out,
	input wire logic [2:0]		port_e_oe,
	input wire logic			slave_port_active
);
	import pspe_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////////////
	property p_wait; hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout; endproperty
	a_wait: assert property (p_wait) else $error("wait state not one cycle");
	property p_hold; $changed(hrdata) |-> $rose(hreadyout); endproperty
	a_hold: assert property (p_hold) else $error("read data moved early");
	property p_e_mode; slave_port_active && $past(slave_port_active) |-> port_e_oe == 3'h0;
	endproperty
	a_e_mode: assert property (p_e_mode) else $error("port e driven in mode");
	property p_d_off; !slave_port_active && !$past(slave_port_active) |-> port_d_oe == 8'h00;
	endproperty
	a_d_off: assert property (p_d_off) else $error("port d driven off mode");
	// a strobe held released for six cycles must have freed the data lines
	property p_d_rd; strobe_in.rd_n [*6] |-> port_d_oe == 8'h00; endproperty
	a_d_rd: assert property (p_d_rd) else $error("port d driven without read");
	property p_d_cs; strobe_in.cs_n [*6] |-> port_d_oe == 8'h00; endproperty
	a_d_cs: assert property (p_d_cs) else $error("port d driven without select");
	property p_w_cfg; warm_reset |=> ##1 !slave_port_active && port_e_oe == 3'h0; endproperty
	a_w_cfg: assert property (p_w_cfg) else $error("warm reset left mode or outputs");
	property p_w_data; warm_reset |=> $stable(port_e_out); endproperty
	a_w_data: assert property (p_w_data) else $error("warm reset changed pin data");
endmodule // pspe_properties
////////////////////////////////////////////////////////////////////////////////
bind pspe_top pspe_properties u_props (.hclk(hclk), .hresetn(hresetn),
	.warm_reset(warm_reset), .hsel(hsel), .htrans(htrans), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .strobe_in(strobe_in), .port_d_oe(port_d_oe),
	.port_e_out(port_e_out), .port_e_oe(port_e_oe), .slave_port_active(slave_port_active));

// ---- pspe_regs.svh ----
// Purpose: register indices, field positions, reset values for the slave port block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef PSPE_REGS_SVH
`define PSPE_REGS_SVH

`define PSPE_IDX_W          8
`define PSPE_IDX_SLAVE_PORT_DATA_LATCH      8'h08
`define PSPE_IDX_PORT_E_PIN_DATA      8'h09
`define PSPE_IDX_STATUS     8'h89
`define PSPE_IDX_ANALOG     8'h9f
`define PSPE_IDX_IRQ_STAT   8'ha0
`define PSPE_IDX_IRQ_MASK   8'ha1

`define PSPE_BIT_IBF        7
`define PSPE_BIT_OBF        6
`define PSPE_BIT_INPUT_OVERFLOW_FLAG       5
`define PSPE_BIT_MODE       4

`define PSPE_STATUS_RST     8'h07
`define PSPE_DIR_RST        3'h7
`define PSPE_ANALOG_RST     3'h0
`define PSPE_IRQ_RST        3'h0

`define PSPE_IRQ_WRITE      0
`define PSPE_IRQ_READ       1
`define PSPE_IRQ_OVF        2

`endif

// ---- pspe_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: destination clock hclk
// Notes:   only the second stage leaves the module
`timescale 1ns/1ps
module pspe_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// reset value is a parameter so the async branch only loads constants
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= RST;
			q      <= RST;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // pspe_sync

// ---- pspe_top.sv ----
// Purpose: slave port status/direction register bank with AHB-Lite access
// Assumes: hresetn is the power-on reset, warm_reset the other resets
// Notes:   one wait state on every bus transfer
// Operation
// - direction bit 1 input, 0 output
// - power-on reset: status 0000-111, data undefined
// - other reset: status 0000-111, data kept
// - unimplemented bits read as zero
// - port D read clears; flags zero outside mode (code clears only ibf and obf there, overflow kept)
// - second write before read sets overflow
// - output full clears when external read starts
// - mode bit makes slave port, strobe inputs
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "pspe_regs.svh"
module pspe_top (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 warm_reset,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire pspe_pkg::pspe_strobe_t strobe_in,
	input  wire logic [7:0]           port_d_in,
	output logic      [7:0]           port_d_out,
	output logic      [7:0]           port_d_oe,
	input  wire logic [2:0]           port_e_in,
	output logic      [2:0]           port_e_out,
	output logic      [2:0]           port_e_oe,
	output logic      [2:0]           analog_config,
	output logic                      slave_port_active,
	output logic                      irq
);
	import pspe_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	pspe_strobe_t strb_s;
	logic [7:0]   pd_s;
	logic [2:0]   pe_s;

	pspe_sync #(.W(3), .RST(3'h7)) u_sync_strb (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (strobe_in),
		.q       (strb_s)
	);

	pspe_sync #(.W(11), .RST(11'h000)) u_sync_data (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       ({port_d_in, port_e_in}),
		.q       ({pd_s, pe_s})
	);

	////////////////////////////////////////////////////////////////////////////
	// state

	pspe_bus_state_t        st_r, st_nxt;
	logic [`PSPE_IDX_W-1:0] idx_r, idx_nxt;
	logic                   wr_r, wr_nxt;
	logic [31:0]            hrdata_nxt;
	logic                   ibf_r, ibf_nxt;
	logic                   obf_r, obf_nxt;
	logic                   input_overflow_flag_r, input_overflow_flag_nxt;
	logic                   mode_r, mode_nxt;
	logic [2:0]             dir_r, dir_nxt;
	logic [2:0]             pe_dat_r, pe_dat_nxt;
	logic [2:0]             acfg_r, acfg_nxt;
	logic [7:0]             din_r, din_nxt;
	logic [7:0]             dout_r, dout_nxt;
	logic [2:0]             ist_r, ist_nxt;
	logic [2:0]             imsk_r, imsk_nxt;
	logic                   wact_r, ract_r;
	logic                   wact, ract;
	pspe_pe_drive_t         pe_nxt;
	logic [7:0]             pd_oe_nxt;

	function automatic logic [7:0] status_word(input logic input_buffer_full_flag, input logic output_buffer_full_flag,
		input logic input_overflow_flag, input logic mode, input logic [2:0] dir);
		// bit 3 is unimplemented and reads zero
		status_word = {input_buffer_full_flag, output_buffer_full_flag, input_overflow_flag, mode, 1'b0, dir};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	logic accept, dphase, fw_rd_pd, wev, rstart, rend;

	always_comb begin
		wact       = mode_r && !strb_s.cs_n && !strb_s.wr_n;
		ract       = mode_r && !strb_s.cs_n && !strb_s.rd_n;
		accept     = hsel && hready && htrans[1];
		dphase     = (st_r == PSPE_DATA);
		fw_rd_pd   = dphase && !wr_r && (idx_r == `PSPE_IDX_SLAVE_PORT_DATA_LATCH);
		wev        = wact_r && !wact; // write ends when cs or wr rises
		rstart     = ract && !ract_r;
		rend       = ract_r && !ract;

		st_nxt     = accept ? PSPE_DATA : PSPE_IDLE;
		idx_nxt    = accept ? haddr[`PSPE_IDX_W+1:2] : idx_r;
		wr_nxt     = accept ? hwrite : wr_r;
		hrdata_nxt = hrdata;
		ibf_nxt    = ibf_r;
		obf_nxt    = obf_r;
		input_overflow_flag_nxt   = input_overflow_flag_r;
		mode_nxt   = mode_r;
		dir_nxt    = dir_r;
		pe_dat_nxt = pe_dat_r;
		acfg_nxt   = acfg_r;
		din_nxt    = wact ? pd_s : din_r;
		dout_nxt   = dout_r;
		ist_nxt    = ist_r;
		imsk_nxt   = imsk_r;

		if (dphase && !wr_r) begin
			unique case (idx_r)
				`PSPE_IDX_SLAVE_PORT_DATA_LATCH:    hrdata_nxt = {24'h000000, din_r};
				`PSPE_IDX_PORT_E_PIN_DATA:    hrdata_nxt = {29'h0, pe_s};
				`PSPE_IDX_STATUS:   hrdata_nxt = {24'h000000,
					status_word(ibf_r, obf_r, input_overflow_flag_r, mode_r, dir_r)};
				`PSPE_IDX_ANALOG:   hrdata_nxt = {29'h0, acfg_r};
				`PSPE_IDX_IRQ_STAT: hrdata_nxt = {29'h0, ist_r};
				`PSPE_IDX_IRQ_MASK: hrdata_nxt = {29'h0, imsk_r};
				default:            hrdata_nxt = 32'h00000000;
			endcase
		end

		if (dphase && wr_r) begin
			unique case (idx_r)
				`PSPE_IDX_SLAVE_PORT_DATA_LATCH: begin
					dout_nxt = hwdata[7:0];
					obf_nxt  = 1'b1;
				end
				`PSPE_IDX_PORT_E_PIN_DATA:  pe_dat_nxt = hwdata[2:0];
				`PSPE_IDX_STATUS: begin
					// ibf and obf are not writable
					input_overflow_flag_nxt = hwdata[`PSPE_BIT_INPUT_OVERFLOW_FLAG];
					mode_nxt = hwdata[`PSPE_BIT_MODE];
					dir_nxt  = hwdata[2:0];
				end
				`PSPE_IDX_ANALOG:   acfg_nxt = hwdata[2:0];
				`PSPE_IDX_IRQ_STAT: ist_nxt = ist_r & ~hwdata[2:0];
				`PSPE_IDX_IRQ_MASK: imsk_nxt = hwdata[2:0];
				default: ;
			endcase
		end

		if (fw_rd_pd)
			ibf_nxt = 1'b0;
		if (wev) begin
			// overflow only if the previous byte stays unread this cycle
			if (ibf_r && !fw_rd_pd)
				input_overflow_flag_nxt = 1'b1;
			ibf_nxt = 1'b1;
			ist_nxt[`PSPE_IRQ_WRITE] = 1'b1;
			if (ibf_r && !fw_rd_pd)
				ist_nxt[`PSPE_IRQ_OVF] = 1'b1;
		end
		if (rstart)
			obf_nxt = 1'b0;
		if (rend)
			ist_nxt[`PSPE_IRQ_READ] = 1'b1;

		// overflow is left alone here: firmware must clear it
		if (!mode_r) begin
			ibf_nxt = 1'b0;
			obf_nxt = 1'b0;
		end

		if (warm_reset) begin
			ibf_nxt  = 1'b0;
			obf_nxt  = 1'b0;
			input_overflow_flag_nxt = 1'b0;
			mode_nxt = 1'b0;
			dir_nxt  = `PSPE_DIR_RST;
			acfg_nxt = `PSPE_ANALOG_RST;
			ist_nxt  = `PSPE_IRQ_RST;
			imsk_nxt = `PSPE_IRQ_RST;
		end

		// in slave mode the three pins are strobe inputs, never driven
		pe_nxt.dout = pe_dat_nxt;
		pe_nxt.oe   = mode_nxt ? 3'h0 : ~dir_nxt;
		pd_oe_nxt   = (mode_r && ract) ? 8'hff : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r      <= PSPE_IDLE;
			idx_r     <= '0;
			wr_r      <= 1'b0;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			ibf_r     <= 1'b0;
			obf_r     <= 1'b0;
			input_overflow_flag_r    <= 1'b0;
			mode_r    <= 1'b0;
			dir_r     <= `PSPE_DIR_RST;
			pe_dat_r  <= 3'h0;
			acfg_r    <= `PSPE_ANALOG_RST;
			din_r     <= 8'h00;
			dout_r    <= 8'h00;
			ist_r     <= `PSPE_IRQ_RST;
			imsk_r    <= `PSPE_IRQ_RST;
			wact_r    <= 1'b0;
			ract_r    <= 1'b0;
			port_d_out    <= 8'h00;
			port_d_oe     <= 8'h00;
			port_e_out    <= 3'h0;
			port_e_oe     <= 3'h0;
			analog_config <= `PSPE_ANALOG_RST;
			slave_port_active <= 1'b0;
			irq       <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			idx_r     <= idx_nxt;
			wr_r      <= wr_nxt;
			hrdata    <= hrdata_nxt;
			// wait state: low in the first data-phase cycle
			hreadyout <= !accept;
			hresp     <= 1'b0;
			ibf_r     <= ibf_nxt;
			obf_r     <= obf_nxt;
			input_overflow_flag_r    <= input_overflow_flag_nxt;
			mode_r    <= mode_nxt;
			dir_r     <= dir_nxt;
			pe_dat_r  <= pe_dat_nxt;
			acfg_r    <= acfg_nxt;
			din_r     <= din_nxt;
			dout_r    <= dout_nxt;
			ist_r     <= ist_nxt;
			imsk_r    <= imsk_nxt;
			wact_r    <= wact;
			ract_r    <= ract;
			port_d_out    <= dout_r;
			port_d_oe     <= pd_oe_nxt;
			port_e_out    <= pe_nxt.dout;
			port_e_oe     <= pe_nxt.oe;
			analog_config <= acfg_nxt;
			slave_port_active <= mode_nxt;
			irq       <= |(ist_nxt & imsk_nxt);
		end
	end

endmodule // pspe_top

// ---- pspe_top_tb.sv ----
// Purpose: self-checking bench of the slave port register bank
// Assumes: single word AHB-Lite transfers, byte address four times index
// Notes:   port e pins driven from pe_in
`timescale 1ns/1ps
`include "pspe_regs.svh"
module pspe_top_tb;
	import pspe_pkg::*;
	localparam logic [7:0] st = `PSPE_IDX_STATUS;
	logic		hclk = 1'b0;
	logic		hresetn = 1'b0;
	logic		warm_reset = 1'b0;
	logic		hsel = 1'b0;
	logic		hwrite = 1'b0;
	logic [1:0]	htrans = 2'h0;
	logic [31:0]	haddr = 32'h0;
	logic [31:0]	hwdata = 32'h0;
	logic [31:0]	hrdata, d;
	logic		hreadyout, hresp, irq, spa;
	logic [7:0]	pdi, pdo, pdoe, xd;
	logic [2:0]	peo, peoe, acfg;
	logic [2:0]	pe_in = 3'h5;
	pspe_strobe_t	stb;
	int		errors = 0;
	int		n_compared = 0;
	always #5 hclk = ~hclk;
	pspe_top dut (.hclk(hclk), .hresetn(hresetn), .warm_reset(warm_reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.strobe_in(stb), .port_d_in(pdi), .port_d_out(pdo), .port_d_oe(pdoe),
		.port_e_in(pe_in), .port_e_out(peo), .port_e_oe(peoe), .analog_config(acfg),
		.slave_port_active(spa), .irq(irq));
	pspe_host u_host (.hclk(hclk), .port_d_out(pdo), .port_d_oe(pdoe), .strobe(stb),
		.pins(pdi));
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int i;
		i = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 40);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 40);
		d = hrdata;
		if (i >= 40) begin
			errors++;
			report_and_stop();
		end
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(d, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(st, 32'h07);
		rd(`PSPE_IDX_ANALOG, 32'h0);
		rd(`PSPE_IDX_PORT_E_PIN_DATA, 32'h5);
		rd(8'h50, 32'h0);
		chk(32'(hresp), 32'h0);
		pe_in <= 3'h2;
		repeat (3) @(posedge hclk);
		rd(`PSPE_IDX_PORT_E_PIN_DATA, 32'h2);
		$display("test reset done");
		xfer(1'b1, st, 32'hff);
		rd(st, 32'h37);
		xfer(1'b1, st, 32'h02);
		rd(st, 32'h02);
		chk(32'(peoe), 32'h5);
		xfer(1'b1, `PSPE_IDX_PORT_E_PIN_DATA, 32'h6);
		xfer(1'b1, `PSPE_IDX_ANALOG, 32'hff);
		rd(`PSPE_IDX_ANALOG, 32'h07);
		chk(32'(acfg), 32'h7);
		chk(32'(peo), 32'h6);
		$display("test direction done");
		xfer(1'b1, `PSPE_IDX_IRQ_MASK, 32'h7);
		xfer(1'b1, st, 32'h17);
		rd(st, 32'h17);
		chk(32'(spa), 32'h1);
		u_host.xwr(8'ha5);
		rd(st, 32'h97);
		chk(32'(irq), 32'h1);
		u_host.xwr(8'h3c);
		rd(st, 32'hb7);
		rd(`PSPE_IDX_SLAVE_PORT_DATA_LATCH, 32'h3c);
		rd(st, 32'h37);
		xfer(1'b1, `PSPE_IDX_SLAVE_PORT_DATA_LATCH, 32'h5a);
		rd(st, 32'h77);
		u_host.xrd(xd);
		chk(32'(xd), 32'h5a);
		rd(st, 32'h37);
		xfer(1'b1, `PSPE_IDX_IRQ_STAT, 32'h7);
		rd(`PSPE_IDX_IRQ_STAT, 32'h0);
		chk(32'(irq), 32'h0);
		$display("test slave port done");
		xfer(1'b1, `PSPE_IDX_IRQ_MASK, 32'h0);
		u_host.xwr(8'h11);
		rd(`PSPE_IDX_IRQ_STAT, 32'h1);
		chk(32'(irq), 32'h0);
		xfer(1'b1, `PSPE_IDX_IRQ_MASK, 32'h1);
		rd(`PSPE_IDX_IRQ_MASK, 32'h1);
		chk(32'(irq), 32'h1);
		xfer(1'b1, st, 32'h27);
		u_host.xwr(8'h22);
		rd(st, 32'h27);
		$display("test interrupt done");
		xfer(1'b1, st, 32'h12);
		warm_reset <= 1'b1;
		@(posedge hclk);
		warm_reset <= 1'b0;
		rd(st, 32'h07);
		chk(32'(peo), 32'h6);
		$display("test warm reset done");
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		rd(st, 32'h07);
		chk(32'(peoe), 32'h0);
		chk(32'(peo), 32'h0);
		$display("test power-on reset done");
		report_and_stop();
	end
endmodule // pspe_top_tb
